// ---- src/fbr_pkg.sv ----
/*
 Constants for the flash linear burst read controller: register map,
 configuration field layout, reset values and controller states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fbr_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0]  CFG_ADDR      = 8'h00;
  localparam logic [7:0]  STAT_ADDR     = 8'h04;
  // Configuration field positions
  localparam int          RM_BIT        = 15;
  localparam int          IAD_LSB       = 10;
  localparam int          IAD_W         = 4;
  localparam int          WC_BIT        = 8;
  localparam int          CC_BIT        = 6;
  localparam int          BL_LSB        = 0;
  localparam int          BL_W          = 3;
  // Default: async, 9-cycle delay, linear, rising edge, 64-byte burst
  localparam logic [15:0] CFG_RESET     = 16'h9cc4;
  // Bits software may change; hold, sequence and reserved bits are fixed
  localparam logic [15:0] CFG_WR_MASK   = 16'h9d47;
  localparam logic [3:0]  DELAY_BASE    = 4'h2;
  localparam logic [2:0]  BL_MAX        = 3'h4;
  // Synchronised pin vector reset: clk low, strobes high, x16 width
  localparam logic [5:0]  PIN_RST       = 6'h1e;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    FBR_IDLE = 3'b001,
    FBR_WAIT = 3'b010,
    FBR_DATA = 3'b100
  } fbr_state_t;
endpackage
`default_nettype wire

// ---- src/fbr_burst_ctrl.sv ----
/*
 Flash linear burst read controller, device side: burst start, abort,
 masking and end-of-burst indication, initial delay, clock edge choice,
 and the configuration register behind an AXI4-Lite slave.
 Assumes all pins come from outside aclk's domain and are sampled by
 aclk much faster than the burst clock, and that the array answers
 array_addr combinationally on array_rdata.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
// Notes on behaviour
// - Chip select high during a burst ends it at once and floats outputs.
// - Burst starts at first clock rise with valid low or valid rising.
// - Valid low mid-burst drops it; a valid rise starts the next one.
// - Hardware reset low stops any burst and floats outputs immediately.
// - Hardware reset restores default configuration, i.e. async reads.
// - Output enable high floats outputs; sequencing keeps advancing.
// - Output enable never ends a burst; outputs float until it is low.
// - Indicator low while the final burst word is on the data lines.
// - With output enable low indicator drives high, then low at end.
// - Indicator changes on the same clock timing as the data word.
// - Initial delay acts on burst reads only.
// - Delay counts clocks from the start edge to first valid data edge.
// - Four-bit delay code 0000 to 0111 gives 2 to 9 clocks.
// - Clock edge bit 1 (default): start and data on rising edges.
// - Clock edge bit 0: same count, data valid after falling edge.
// - Each data word is held for exactly one clock.
// - Clocking past the last transfer wraps to the burst start address.
// - Read mode bit 0 enables bursts; 1 (default) selects async reads.
// - Burst length code 1..4 gives 8..64 bytes, x32 only 1..3; others disable bursts.
// - Indicator timing bit 1 moves the indicator one data cycle early.
`timescale 1ns/10ps
`default_nettype none
module fbr_burst_ctrl #(
  parameter int ADDR_W = 20
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              burst_clk,
  input  wire logic              chip_select_n,
  input  wire logic              address_valid_n,
  input  wire logic              output_enable_n,
  input  wire logic              hw_reset_n,
  input  wire logic              word_mode_32,
  input  wire logic [ADDR_W-1:0] burst_address,
  output logic [31:0]            data_lines_out,
  output logic                   data_lines_oe_n,
  output logic                   end_of_burst_indicator_out,
  output logic                   end_of_burst_indicator_oe_n,
  output logic [ADDR_W-1:0]      array_addr,
  input  wire logic [31:0]       array_rdata
);

  logic [5:0]        pin_s1;
  logic [5:0]        pin_s2;
  logic [5:0]        pin_s3;
  logic [ADDR_W-1:0] addr_s1;
  logic [ADDR_W-1:0] addr_s2;
  logic              bclk_rise;
  logic              bclk_fall;
  logic              cs_hi;
  logic              adv_lo;
  logic              adv_rise;
  logic              adv_fall;
  logic              oe_lo;
  logic              hw_lo;
  logic              w32;

  // Two stages before use; third stage only for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1  <= fbr_pkg::PIN_RST;
      pin_s2  <= fbr_pkg::PIN_RST;
      pin_s3  <= fbr_pkg::PIN_RST;
      addr_s1 <= '0;
      addr_s2 <= '0;
    end else begin
      pin_s1  <= {burst_clk, chip_select_n, address_valid_n,
                  output_enable_n, hw_reset_n, word_mode_32};
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      addr_s1 <= burst_address;
      addr_s2 <= addr_s1;
    end
  end

  assign bclk_rise = pin_s2[5] & ~pin_s3[5];
  assign bclk_fall = ~pin_s2[5] & pin_s3[5];
  assign cs_hi     = pin_s2[4];
  assign adv_lo    = ~pin_s2[3];
  assign adv_rise  = pin_s2[3] & ~pin_s3[3];
  assign adv_fall  = ~pin_s2[3] & pin_s3[3];
  assign oe_lo     = ~pin_s2[2];
  assign hw_lo     = ~pin_s2[1];
  assign w32       = pin_s2[0];

  // Register bus: one write and one read at a time
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_cfg;
  logic        wr_hit;
  logic [15:0] wmask;
  logic [15:0] cfg;

  assign awready = ~aw_got;
  assign wready  = ~w_got;
  assign arready = ~rvalid;
  assign wr_fire = aw_got & w_got & ~bvalid;
  assign wr_cfg  = aw_addr_q[7:2] == fbr_pkg::CFG_ADDR[7:2];
  assign wr_hit  = wr_cfg | (aw_addr_q[7:2] == fbr_pkg::STAT_ADDR[7:2]);
  assign wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}}
                   & fbr_pkg::CFG_WR_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got    <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && !aw_got) begin
      aw_got    <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_got    <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got    <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && !w_got) begin
      w_got    <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_fire) begin
      w_got    <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= fbr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? fbr_pkg::RESP_OKAY : fbr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Pin reset wins over a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_lo) begin
      cfg <= fbr_pkg::CFG_RESET;
    end else if (wr_fire && wr_cfg) begin
      cfg <= (cfg & ~wmask) | (w_data_q[15:0] & wmask);
    end
  end

  logic [2:0] bl;
  logic       burst_en;
  logic [2:0] len_log;
  logic [4:0] len_mask;
  logic [3:0] lat_load;
  logic       rise_mode;
  logic [4:0] eob_pos;

  assign bl        = cfg[fbr_pkg::BL_LSB +: fbr_pkg::BL_W];
  // x32 cannot carry the 64-byte length
  assign burst_en  = ~cfg[fbr_pkg::RM_BIT] & (bl != 3'h0)
                     & (bl <= fbr_pkg::BL_MAX)
                     & ~(w32 & (bl == fbr_pkg::BL_MAX));
  assign len_log   = w32 ? bl : 3'(bl + 3'h1);
  assign len_mask  = 5'((6'h01 << len_log) - 6'h01);
  assign lat_load  = 4'(cfg[fbr_pkg::IAD_LSB +: fbr_pkg::IAD_W]
                     + fbr_pkg::DELAY_BASE - 4'h1);
  assign rise_mode = cfg[fbr_pkg::CC_BIT];
  assign eob_pos   = len_mask - {4'h0, cfg[fbr_pkg::WC_BIT]};

  fbr_pkg::fbr_state_t state;
  logic              adv_used;
  logic              aborted;
  logic [3:0]        lat_cnt;
  logic [4:0]        idx;
  logic [4:0]        xfer;
  logic [ADDR_W-1:0] base_q;
  logic [31:0]       data_q;
  logic              eob_q;
  logic              start;
  logic              step;
  logic              busy;

  assign busy  = state != fbr_pkg::FBR_IDLE;
  // Edge start blocked after an abort until valid rises again
  assign start = burst_en & ~cs_hi & ~adv_used
                 & ((bclk_rise & adv_lo & ~aborted) | adv_rise);
  // Delay only ever counted inside a burst
  assign step  = busy & (rise_mode
                 ? (bclk_rise & (lat_cnt <= 4'h1))
                 : (bclk_fall & (lat_cnt == 4'h0)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adv_used <= 1'b0;
    end else if (start) begin
      adv_used <= 1'b1;
    end else if (!adv_lo) begin
      adv_used <= 1'b0;
    end
  end

  // Output enable does not appear here: it only masks the pins
  always_ff @(posedge aclk) begin
    if (!aresetn || hw_lo || cs_hi) begin
      state   <= fbr_pkg::FBR_IDLE;
      aborted <= 1'b0;
    end else if (adv_fall && busy) begin
      state   <= fbr_pkg::FBR_IDLE;
      aborted <= 1'b1;
    end else if (start) begin
      state   <= fbr_pkg::FBR_WAIT;
      aborted <= 1'b0;
    end else begin
      case (state)
        fbr_pkg::FBR_IDLE: state <= fbr_pkg::FBR_IDLE;
        fbr_pkg::FBR_WAIT: begin
          if (step) begin
            state <= fbr_pkg::FBR_DATA;
          end
        end
        fbr_pkg::FBR_DATA: state <= fbr_pkg::FBR_DATA;
        default: state <= fbr_pkg::FBR_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_cnt <= 4'h0;
    end else if (start) begin
      lat_cnt <= lat_load;
    end else if (busy && bclk_rise && lat_cnt != 4'h0) begin
      lat_cnt <= lat_cnt - 4'h1;
    end
  end

  // Sequencing runs on whether or not the pins are enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_q <= '0;
      idx    <= 5'h00;
      xfer   <= 5'h00;
    end else if (start) begin
      base_q <= addr_s2;
      idx    <= addr_s2[4:0] & len_mask;
      xfer   <= 5'h00;
    end else if (step) begin
      idx    <= 5'(idx + 5'h01) & len_mask;
      xfer   <= (xfer == len_mask) ? 5'h00 : 5'(xfer + 5'h01);
    end
  end

  assign array_addr = (base_q & ~ADDR_W'(len_mask)) | ADDR_W'(idx);

  // Word and indicator share one update, one word per step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= 32'h0000_0000;
      eob_q  <= 1'b0;
    end else if (step) begin
      data_q <= array_rdata;
      eob_q  <= xfer == eob_pos;
    end
  end

  // Pin state follows the synchronised strobes without waiting a cycle
  assign data_lines_out  = data_q;
  assign data_lines_oe_n = ~((state == fbr_pkg::FBR_DATA) & oe_lo
                             & ~cs_hi & ~hw_lo);
  assign end_of_burst_indicator_out =
      ~((state == fbr_pkg::FBR_DATA) & eob_q);
  assign end_of_burst_indicator_oe_n =
      ~(busy & oe_lo & ~cs_hi & ~hw_lo);

  logic [31:0] stat_word;
  logic        rd_cfg;
  logic        rd_stat;

  assign stat_word = {18'h00000, w32, xfer, lat_cnt, aborted,
                      state == fbr_pkg::FBR_DATA, busy, burst_en};
  assign rd_cfg    = araddr[7:2] == fbr_pkg::CFG_ADDR[7:2];
  assign rd_stat   = araddr[7:2] == fbr_pkg::STAT_ADDR[7:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= fbr_pkg::RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_cfg ? {16'h0000, cfg} : (rd_stat ? stat_word : '0);
      rresp  <= (rd_cfg | rd_stat) ? fbr_pkg::RESP_OKAY
                                   : fbr_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- verif/fbr_props.sv ----
/* Checker for fbr_burst_ctrl pin float and bus answer timing.
 Sees only the top ports; bound after the module. */
`timescale 1ns/10ps
`default_nettype none
module fbr_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        hw_reset_n,
  input wire logic [31:0] data_lines_out,
  input wire logic        data_lines_oe_n,
  input wire logic        end_of_burst_indicator_out,
  input wire logic        end_of_burst_indicator_oe_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Four samples cover the pin synchroniser delay
  AST_CS_FLOAT: assert property (chip_select_n [*4] |-> data_lines_oe_n && end_of_burst_indicator_oe_n) else $error("cs high, outputs driven");
  AST_HWR_FLOAT: assert property (!hw_reset_n [*4] |-> data_lines_oe_n && end_of_burst_indicator_oe_n) else $error("reset low, outputs driven");
  AST_OE_FLOAT: assert property (output_enable_n [*4] |-> data_lines_oe_n && end_of_burst_indicator_oe_n) else $error("oe high, outputs driven");
  // Indicator is driven through the delay too, so only one direction holds
  AST_IND_OE: assert property (!data_lines_oe_n |-> !end_of_burst_indicator_oe_n) else $error("data driven, indicator floating");
  AST_IND_TIME: assert property ($changed(end_of_burst_indicator_out) && !end_of_burst_indicator_oe_n && !$past(end_of_burst_indicator_oe_n) |-> $changed(data_lines_out)) else $error("indicator moved without data");
  // Both items are held for one cycle before the answer is raised
  AST_B_ANS: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  AST_R_ANS: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read answer dropped");
  cover property ($fell(end_of_burst_indicator_out));
  cover property ($fell(data_lines_oe_n));
  cover property (bvalid && bready);
endmodule
bind fbr_burst_ctrl fbr_props u_props (.*);
`default_nettype wire

// ---- verif/fbr_host.sv ----
/* Host side burst clock source for the burst controller bench.
 Assumes aclk free running; run frames the clock. */
`timescale 1ns/10ps
`default_nettype none
module fbr_host (
  input  wire logic aclk,
  input  wire logic run,
  output logic      burst_clk,
  output logic      pre_rise,
  output logic      mid_high
);
  logic [3:0] cnt;
  // Stands still low between frames; 8 aclk a phase for the synchroniser
  always_ff @(posedge aclk) begin
    cnt <= run ? cnt + 4'h1 : 4'h0;
  end
  assign burst_clk = cnt[3];
  assign pre_rise  = run && cnt == 4'h7;
  assign mid_high  = run && cnt == 4'he;
endmodule
`default_nettype wire

// ---- verif/tb_flash_linear_burst_read_control.sv ----
/* Self-checking bench for fbr_burst_ctrl: register bus, bursts, aborts.
 Assumes the host model supplies the burst clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_flash_linear_burst_read_control;
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, pre_rise, mid_high;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, burst_clk, chip_select_n;
  logic address_valid_n, output_enable_n, hw_reset_n, word_mode_32;
  logic data_lines_oe_n, end_of_burst_indicator_out, ind_oe_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, data_lines_out;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [19:0] burst_address, array_addr;
  int miscompares = 0, n_tests = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  fbr_host u_host (.aclk(aclk), .run(run), .burst_clk(burst_clk),
    .pre_rise(pre_rise), .mid_high(mid_high));
  fbr_burst_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .burst_clk(burst_clk), .chip_select_n(chip_select_n),
    .address_valid_n(address_valid_n), .output_enable_n(output_enable_n),
    .hw_reset_n(hw_reset_n), .word_mode_32(word_mode_32),
    .burst_address(burst_address), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n),
    .end_of_burst_indicator_out(end_of_burst_indicator_out),
    .end_of_burst_indicator_oe_n(ind_oe_n), .array_addr(array_addr),
    .array_rdata({12'h0, array_addr}));
  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hw, bv;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awvalid && awready; hw = wvalid && wready; bv = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!bv);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, rv;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arvalid && arready; rv = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
  endtask
  task automatic stop();
    @(posedge aclk);
    chip_select_n <= 1'b1; run <= 1'b0;
    repeat (5) @(negedge aclk);
    chk({ind_oe_n, data_lines_oe_n}, 2'h3);
    @(posedge aclk);
    address_valid_n <= 1'b1; output_enable_n <= 1'b1;
  endtask
  task automatic burst(input logic [15:0] cfg, input logic [19:0] a,
                       input logic x, input int gap);
    int d, len, n, k;
    logic [19:0] w;
    logic [1:0] r;
    d = cfg[13:10] + 2;
    len = x ? (1 << cfg[2:0]) : (2 << cfg[2:0]);
    wr(fbr_pkg::CFG_ADDR, {16'h0, cfg}, r);
    @(posedge aclk);
    word_mode_32 <= x; burst_address <= a; run <= 1'b1;
    chip_select_n <= 1'b0; address_valid_n <= 1'b0;
    output_enable_n <= 1'b0;
    n = 0;
    while (n < d + len + 2) begin
      @(negedge aclk);
      if (mid_high && n == d) chk(data_lines_oe_n, !cfg[6]);
      if (pre_rise) begin
        k = n - d;
        // Sampled just before the edge where the word is valid
        if (k == gap) chk(data_lines_oe_n, 1'b1);
        else if (k >= 0) begin
          w = 20'((a & ~(len - 1)) | ((a + k) & (len - 1)));
          chk(data_lines_out[15:0], w[15:0]);
          chk(end_of_burst_indicator_out,
              (k % len) != (len - 1 - cfg[8]));
        end
        n++;
        @(posedge aclk);
        output_enable_n <= (k + 1 == gap);
      end
    end
    stop();
  endtask
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0] r;
    rd(fbr_pkg::CFG_ADDR, d, r);
    chk(d, {16'h0, fbr_pkg::CFG_RESET});
    wr(fbr_pkg::CFG_ADDR, 32'hffffffff, r);
    rd(fbr_pkg::CFG_ADDR, d, r);
    chk(d, {16'h0, fbr_pkg::CFG_WR_MASK |
        (fbr_pkg::CFG_RESET & ~fbr_pkg::CFG_WR_MASK)});
    rd(8'h08, d, r);
    chk(r, fbr_pkg::RESP_SLVERR);
    wr(8'h0c, 32'h0, r);
    chk(r, fbr_pkg::RESP_SLVERR);
  endtask
  task automatic s_abort();
    logic [1:0] r;
    wr(fbr_pkg::CFG_ADDR, 32'h000004c1, r);
    @(posedge aclk);
    run <= 1'b1; chip_select_n <= 1'b0; address_valid_n <= 1'b0;
    output_enable_n <= 1'b0; burst_address <= 20'h00020;
    // Valid pulse rises with a burst clock rise, falls in its high phase
    repeat (40) @(posedge aclk);
    address_valid_n <= 1'b1;
    repeat (4) @(posedge aclk);
    address_valid_n <= 1'b0;
    repeat (5) @(negedge aclk);
    chk({ind_oe_n, data_lines_oe_n}, 2'h3);
    @(posedge aclk);
    burst_address <= 20'h00031; address_valid_n <= 1'b1;
    while (data_lines_oe_n) @(negedge aclk);
    chk(data_lines_out[15:0], 16'h0031);
    stop();
  endtask
  task automatic s_hwreset();
    logic [31:0] d;
    logic [1:0] r;
    wr(fbr_pkg::CFG_ADDR, 32'h000004c1, r);
    @(posedge aclk);
    run <= 1'b1; chip_select_n <= 1'b0; address_valid_n <= 1'b0;
    output_enable_n <= 1'b0;
    repeat (60) @(posedge aclk);
    hw_reset_n <= 1'b0;
    repeat (5) @(negedge aclk);
    chk({ind_oe_n, data_lines_oe_n}, 2'h3);
    rd(fbr_pkg::CFG_ADDR, d, r);
    chk(d, {16'h0, fbr_pkg::CFG_RESET});
    hw_reset_n <= 1'b1;
    // Pins stay low and clocked, yet async default allows no burst
    repeat (60) @(negedge aclk);
    chk(data_lines_oe_n, 1'b1);
    stop();
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, word_mode_32} = 6'h0;
    {chip_select_n, address_valid_n, output_enable_n, hw_reset_n} = 4'hf;
    {awaddr, araddr, wdata, wstrb, burst_address} = 72'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    s_regs();
    burst(16'h04c1, 20'h00006, 1'b0, 99);
    burst(16'h1dc2, 20'h00045, 1'b1, 2);
    burst(16'h0083, 20'h0000b, 1'b0, 99);
    burst(16'h08c4, 20'h0001f, 1'b0, 99);
    s_abort();
    s_hwreset();
    wrap_up();
  end
endmodule
`default_nettype wire
